// ===== ld_config_pkg.sv
/*
 * Constants and the state type for the configuration register bank that
 * serves the timeout supervisor, joystick port and MIDI port logical devices.
 * Assumes a single 25 MHz clock domain and a 32-bit AHB-Lite register bus.
 */
package ld_config_pkg;

    // Logical device numbers, taken from byte address bits 11:10
    localparam logic [1:0] LD_TIMEOUT  = 2'h0;
    localparam logic [1:0] LD_JOYSTICK = 2'h1;
    localparam logic [1:0] LD_MIDI     = 2'h2;
    localparam int         LD_LSB      = 10;
    localparam int         IDX_LSB     = 2;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI  = 8'h60;
    localparam logic [7:0] IDX_BASE_LO  = 8'h61;
    localparam logic [7:0] IDX_IRQ_SEL  = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_A    = 8'h74;
    localparam logic [7:0] IDX_DMA_B    = 8'h75;
    localparam logic [7:0] IDX_CONTROL  = 8'hf0;

    // Field positions
    localparam int ACT_ENABLE      = 0;
    localparam int CTRL_TRISTATE   = 0;
    localparam int CTRL_POWER      = 1;
    localparam int CTRL_PULLUP     = 2;
    localparam int CTRL_OUT_TYPE   = 3;
    localparam int CTRL_ENHANCED   = 3;
    localparam int IRQ_WAKE_EN     = 4;
    localparam int IRQ_NUM_LSB     = 0;
    localparam int IRQ_NUM_W       = 4;
    localparam int JOY_ALIGN_W     = 4;

    // Fixed read values and write masks; array entry [n] is logical device n
    localparam logic [7:0]      DMA_NONE      = 8'h04;
    localparam logic [7:0]      ACT_WMASK     = 8'h01;
    localparam logic [7:0]      IRQ_TYPE_RST  = 8'h03;
    localparam logic [7:0]      IRQ_TYPE_WMASK = 8'h02;
    localparam logic [2:0][7:0] BASE_LO_WMASK = {8'hfe, 8'hff, 8'hfc};
    localparam logic [2:0][7:0] CTRL_WMASK    = {8'h0d, 8'h0d, 8'h0f};

    // Reset values
    localparam logic [2:0][7:0] BASE_HI_RST = {8'h03, 8'h02, 8'h00};
    localparam logic [2:0][7:0] BASE_LO_RST = {8'h30, 8'h01, 8'h00};
    localparam logic [2:0][7:0] CTRL_RST    = {8'h00, 8'h00, 8'h02};

    // Whole state of the bank: registers plus the bus data-phase context
    typedef struct packed {
        logic [2:0][7:0] act;
        logic [2:0][7:0] base_hi;
        logic [2:0][7:0] base_lo;
        logic [2:0][7:0] irq_sel;
        logic [2:0][7:0] irq_type;
        logic [2:0][7:0] ctrl;
        logic            wr_pend;
        logic [1:0]      wr_ld;
        logic [7:0]      wr_idx;
        logic [31:0]     rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        act:      '0,
        base_hi:  BASE_HI_RST,
        base_lo:  BASE_LO_RST,
        irq_sel:  '0,
        irq_type: {3{IRQ_TYPE_RST}},
        ctrl:     CTRL_RST,
        wr_pend:  1'b0,
        wr_ld:    2'h0,
        wr_idx:   8'h00,
        rdata:    32'h0000_0000
    };

endpackage : ld_config_pkg

// ===== ld_config_bank.sv
/*
 * Configuration register bank for the timeout supervisor, joystick port and
 * MIDI port logical devices, reached over an AHB-Lite slave port.
 * Assumes the datapaths of the three functions sit outside and obey the
 * access, mode and pad-control levels driven here; all inputs are synchronous.
 */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Behaviour
// R1: Activate bit 0 clear blocks all runtime register access of that device.
// R2: Timeout base low byte bits 1:0 read zero and ignore writes.
// R3: Timeout irq select register routes the timeout event, with wake-up enable.
// R4: Interrupt type: only bit 1 writable, others read-only, reset value 03h.
// R5: Both DMA report registers of every device are read-only and return 04h.
// R6: Timeout control bit 3 picks push-pull (1) or open-drain (0) output.
// R7: Timeout control bit 2 enables the pull-up on the timeout output pin.
// R8: Timeout control bit 1 clear stops the timer clock, forces output high.
// R9: Timeout control bit 1 set runs the timer whenever the device is active.
// R10: Control bit 0 set floats an inactive device's output pins.
// R11: Timeout control register resets to 02h.
// R12: Joystick legacy mode exposes only the legacy status at the base address.
// R13: Joystick base bits 3:0 nonzero forces legacy mode.
// R14: Joystick full register set needs enhanced bit and 16-byte aligned base.
// R15: Joystick control bit 2 enables button pull-ups when joystick pins selected.
// R16: MIDI base low byte bit 0 reads zero and ignores writes.
// R17: MIDI control bit 3 selects enhanced (1) or legacy (0) mode.
// R18: MIDI control bit 2 enables the pull-up on the MIDI receive input.
// R19: Software should put the joystick base in the wide generic decode range.
// R20: MIDI legacy mode exposes only receive, transmit, status and command.
// R21: MIDI enhanced mode exposes the complete MIDI register set.
// R22: Reserved control bits read zero and ignore writes.
module ld_config_bank (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    // Runtime access enables and pin float controls, one per logical device
    output logic [2:0]       runtime_access_out,
    output logic [2:0]       pins_tristate_out,
    // Timeout supervisor
    input  wire logic        timeout_event_in,
    output logic             timeout_clk_en_out,
    output logic             timeout_output_force_high_out,
    output logic             timeout_output_push_pull_out,
    output logic             timeout_output_pullup_out,
    output logic [3:0]       timeout_irq_line_out,
    output logic             timeout_irq_req_out,
    output logic             timeout_wake_out,
    output logic [15:0]      timeout_supervisor_base_out,
    // Joystick port
    input  wire logic        joystick_pins_selected_in,
    output logic             joystick_legacy_only_out,
    output logic             joystick_full_set_out,
    output logic [15:0]      joystick_port_base_out,
    output logic [3:0]       joystick_button_pullup_out,
    // MIDI port
    output logic             midi_legacy_only_out,
    output logic             midi_full_set_out,
    output logic [15:0]      midi_port_base_out,
    output logic             midi_receive_pullup_out
);

    ld_config_pkg::state_t st_q;
    ld_config_pkg::state_t st_d;
    logic                  accept;

    // Masked byte update: only bits set in the mask take the new value
    function automatic logic [7:0] masked(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic [7:0] mask);
        masked = (old_v & ~mask) | (new_v & mask);
    endfunction : masked

    // Read decode of one register; unmapped devices and indices read zero
    function automatic logic [7:0] reg_read(input ld_config_pkg::state_t s, input logic [1:0] ld,
                                            input logic [7:0] idx);
        reg_read = 8'h00;
        if (ld != 2'h3) begin
            case (idx)
                ld_config_pkg::IDX_ACTIVATE: reg_read = s.act[ld];
                ld_config_pkg::IDX_BASE_HI:  reg_read = s.base_hi[ld];
                ld_config_pkg::IDX_BASE_LO:  reg_read = s.base_lo[ld];      // [R2] [R16]
                ld_config_pkg::IDX_IRQ_SEL:  reg_read = s.irq_sel[ld];
                ld_config_pkg::IDX_IRQ_TYPE: reg_read = s.irq_type[ld];     // [R4]
                ld_config_pkg::IDX_DMA_A:    reg_read = ld_config_pkg::DMA_NONE; // [R5]
                ld_config_pkg::IDX_DMA_B:    reg_read = ld_config_pkg::DMA_NONE; // [R5]
                ld_config_pkg::IDX_CONTROL:  reg_read = s.ctrl[ld];         // [R22]
                default:                     reg_read = 8'h00;
            endcase
        end
    endfunction : reg_read

    // Transfer taken in the address phase; every transfer is a whole word.
    // Address bits 11:10 pick the logical device and bits 9:2 the index;
    // higher address bits and the byte lanes above 7:0 are ignored, so
    // software must not rely on aliases staying free in a later revision.
    assign accept = hsel_in & htrans_in[1] & hready_in;

    // Next state: finish the pending write, then capture the new address phase.
    // Read data is decoded from the updated state so a read right after a
    // write to the same register already sees the new value.
    always_comb begin
        st_d = st_q;
        if (st_q.wr_pend && st_q.wr_ld != 2'h3) begin
            case (st_q.wr_idx)
                ld_config_pkg::IDX_ACTIVATE:
                    st_d.act[st_q.wr_ld] = masked(st_q.act[st_q.wr_ld], hwdata_in[7:0],
                                                  ld_config_pkg::ACT_WMASK);
                ld_config_pkg::IDX_BASE_HI:
                    st_d.base_hi[st_q.wr_ld] = hwdata_in[7:0];
                ld_config_pkg::IDX_BASE_LO:
                    st_d.base_lo[st_q.wr_ld] = masked(st_q.base_lo[st_q.wr_ld], hwdata_in[7:0],
                                                      ld_config_pkg::BASE_LO_WMASK[st_q.wr_ld]); // [R2] [R16]
                ld_config_pkg::IDX_IRQ_SEL:
                    st_d.irq_sel[st_q.wr_ld] = hwdata_in[7:0];
                ld_config_pkg::IDX_IRQ_TYPE:
                    st_d.irq_type[st_q.wr_ld] = masked(st_q.irq_type[st_q.wr_ld], hwdata_in[7:0],
                                                       ld_config_pkg::IRQ_TYPE_WMASK); // [R4]
                ld_config_pkg::IDX_CONTROL:
                    st_d.ctrl[st_q.wr_ld] = masked(st_q.ctrl[st_q.wr_ld], hwdata_in[7:0],
                                                   ld_config_pkg::CTRL_WMASK[st_q.wr_ld]); // [R22]
                default: ;  // DMA reports and unmapped indices ignore writes [R5]
            endcase
        end
        st_d.wr_pend = accept & hwrite_in;
        st_d.wr_ld   = haddr_in[ld_config_pkg::LD_LSB +: 2];
        st_d.wr_idx  = haddr_in[ld_config_pkg::IDX_LSB +: 8];
        st_d.rdata   = 32'h0000_0000;
        if (accept && !hwrite_in) begin
            st_d.rdata = {24'h00_0000, reg_read(st_d, haddr_in[ld_config_pkg::LD_LSB +: 2],
                                                haddr_in[ld_config_pkg::IDX_LSB +: 8])};
        end
    end

    // State register; reset loads documented defaults
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= ld_config_pkg::STATE_RST;  // [R11]
        end else begin
            st_q <= st_d;
        end
    end

    // Zero wait states and an OKAY response to everything
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = st_q.rdata;

    // Per-device access gate and pin float control
    for (genvar i = 0; i < 3; i++) begin : g_ld
        assign runtime_access_out[i] = st_q.act[i][ld_config_pkg::ACT_ENABLE];  // [R1]
        assign pins_tristate_out[i]  = st_q.ctrl[i][ld_config_pkg::CTRL_TRISTATE]
                                       & ~st_q.act[i][ld_config_pkg::ACT_ENABLE]; // [R10]
    end

    // Timeout supervisor: clock gating, pad type and event routing.
    // Low-power mode leaves the registers reachable; the timer stops and its output is forced high.
    assign timeout_clk_en_out = st_q.ctrl[0][ld_config_pkg::CTRL_POWER]
                                & st_q.act[0][ld_config_pkg::ACT_ENABLE];      // [R8] [R9]
    assign timeout_output_force_high_out = ~st_q.ctrl[0][ld_config_pkg::CTRL_POWER]; // [R8]
    assign timeout_output_push_pull_out  = st_q.ctrl[0][ld_config_pkg::CTRL_OUT_TYPE]; // [R6]
    assign timeout_output_pullup_out     = st_q.ctrl[0][ld_config_pkg::CTRL_PULLUP];   // [R7]
    assign timeout_irq_line_out = st_q.irq_sel[0][ld_config_pkg::IRQ_NUM_LSB +: ld_config_pkg::IRQ_NUM_W]; // [R3]
    // Line zero means no routing, so the event is dropped rather than misrouted
    assign timeout_irq_req_out  = timeout_event_in & (timeout_irq_line_out != 4'h0); // [R3]
    assign timeout_wake_out     = timeout_irq_req_out
                                  & st_q.irq_sel[0][ld_config_pkg::IRQ_WAKE_EN]; // [R3]
    assign timeout_supervisor_base_out = {st_q.base_hi[0], st_q.base_lo[0]};

    // Joystick port: enhanced only with an aligned base; the host must also
    // place that base in its wide decode window, which is not checked here
    assign joystick_port_base_out = {st_q.base_hi[1], st_q.base_lo[1]};
    assign joystick_full_set_out  = st_q.act[1][ld_config_pkg::ACT_ENABLE]
                                    & st_q.ctrl[1][ld_config_pkg::CTRL_ENHANCED]
                                    & (st_q.base_lo[1][ld_config_pkg::JOY_ALIGN_W-1:0] == 4'h0); // [R13] [R14]
    assign joystick_legacy_only_out = st_q.act[1][ld_config_pkg::ACT_ENABLE]
                                      & ~joystick_full_set_out;                // [R12] [R13]
    assign joystick_button_pullup_out = {4{st_q.ctrl[1][ld_config_pkg::CTRL_PULLUP]
                                           & joystick_pins_selected_in}};      // [R15]

    // MIDI port mode and pad control
    assign midi_port_base_out   = {st_q.base_hi[2], st_q.base_lo[2]};
    assign midi_full_set_out    = st_q.act[2][ld_config_pkg::ACT_ENABLE]
                                  & st_q.ctrl[2][ld_config_pkg::CTRL_ENHANCED]; // [R17] [R21]
    assign midi_legacy_only_out = st_q.act[2][ld_config_pkg::ACT_ENABLE]
                                  & ~st_q.ctrl[2][ld_config_pkg::CTRL_ENHANCED]; // [R17] [R20]
    assign midi_receive_pullup_out = st_q.ctrl[2][ld_config_pkg::CTRL_PULLUP];  // [R18]

    // Checks on the bank's own behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_ACCESS_GATE: assert property ( // [R1]
        runtime_access_out == {st_q.act[2][0], st_q.act[1][0], st_q.act[0][0]}
        && !(midi_full_set_out || midi_legacy_only_out) == !st_q.act[2][0])
        else $error("runtime access not gated by activate bit");

    AST_BASE_ALIGN: assert property ( // [R2]
        accept && !hwrite_in && haddr_in[11:2] == {2'h0, 8'h61} |=> hrdata_out[1:0] == 2'b00)
        else $error("timeout base low bits not reading zero");

    AST_MIDI_BASE_BIT0: assert property ( // [R16]
        st_q.wr_pend && st_q.wr_ld == 2'h2 && st_q.wr_idx == 8'h61
        |=> st_q.base_lo[2] == {$past(hwdata_in[7:1]), 1'b0})
        else $error("MIDI base low write not masked correctly");

    AST_IRQ_TYPE: assert property ( // [R4]
        st_q.wr_pend && st_q.wr_idx == 8'h71 && st_q.wr_ld != 2'h3
        |=> st_q.irq_type[$past(st_q.wr_ld)] == {6'h00, $past(hwdata_in[1]), 1'b1})
        else $error("interrupt type register wrote beyond bit 1");

    AST_DMA_REPORT: assert property ( // [R5]
        accept && !hwrite_in && haddr_in[11:10] != 2'h3
        && (haddr_in[9:2] == 8'h74 || haddr_in[9:2] == 8'h75)
        |=> hrdata_out == 32'h0000_0004)
        else $error("DMA report did not return 04h");

    AST_LOW_POWER: assert property ( // [R8]
        !st_q.ctrl[0][1] |-> !timeout_clk_en_out && timeout_output_force_high_out)
        else $error("timer not stopped in low power mode");

    // Normal power plus an active device must always run the timer clock
    AST_TIMER_RUN: assert property ( // [R9]
        st_q.act[0][0] && st_q.ctrl[0][1] |-> timeout_clk_en_out)
        else $error("timer clock not running while active");

    AST_TRISTATE: assert property ( // [R10]
        pins_tristate_out[1] == (st_q.ctrl[1][0] && !st_q.act[1][0]))
        else $error("joystick pins float control wrong");

    AST_CTRL_RESET: assert property ( // [R11]
        $fell(rst_in) |-> st_q.ctrl[0] == 8'h02 && timeout_clk_en_out == 1'b0)
        else $error("timeout control did not reset to 02h");

    AST_JOY_MODE: assert property ( // [R13]
        st_q.act[1][0] && st_q.base_lo[1][3:0] != 4'h0 |-> joystick_legacy_only_out && !joystick_full_set_out)
        else $error("misaligned joystick base not forced to legacy");

    AST_CTRL_WRITE: assert property ( // [R22]
        st_q.wr_pend && st_q.wr_idx == 8'hf0 && st_q.wr_ld == 2'h1
        |=> st_q.ctrl[1] == ($past(hwdata_in[7:0]) & 8'h0d))
        else $error("joystick control reserved bits not cleared");

    // Activate keeps only bit 0; the rest read back as zero
    AST_ACT_WRITE: assert property ( // [R1]
        st_q.wr_pend && st_q.wr_idx == 8'h30 && st_q.wr_ld != 2'h3
        |=> st_q.act[$past(st_q.wr_ld)] == {7'h00, $past(hwdata_in[0])})
        else $error("activate register stored more than bit 0");

    AST_TIMEOUT_BASE_WRITE: assert property ( // [R2]
        st_q.wr_pend && st_q.wr_ld == 2'h0 && st_q.wr_idx == 8'h61
        |=> st_q.base_lo[0] == {$past(hwdata_in[7:2]), 2'h0})
        else $error("timeout base low write not masked correctly");

    // Event routing follows the line number and the wake-up enable
    AST_IRQ_ROUTE: assert property ( // [R3]
        timeout_irq_line_out == st_q.irq_sel[0][3:0]
        && timeout_irq_req_out == (timeout_event_in && st_q.irq_sel[0][3:0] != 4'h0)
        && timeout_wake_out == (timeout_irq_req_out && st_q.irq_sel[0][4]))
        else $error("timeout event routing wrong");

    AST_OUT_TYPE: assert property ( // [R6]
        timeout_output_push_pull_out == st_q.ctrl[0][3])
        else $error("timeout output buffer type wrong");

    AST_OUT_PULLUP: assert property ( // [R7]
        timeout_output_pullup_out == st_q.ctrl[0][2])
        else $error("timeout output pull-up wrong");

    AST_JOY_LEGACY: assert property ( // [R12]
        !st_q.ctrl[1][3] |-> !joystick_full_set_out && joystick_legacy_only_out == st_q.act[1][0])
        else $error("joystick legacy mode not selected");

    AST_JOY_FULL: assert property ( // [R14]
        joystick_full_set_out
        == (st_q.act[1][0] && st_q.ctrl[1][3] && st_q.base_lo[1][3:0] == 4'h0))
        else $error("joystick full register set exposed wrongly");

    AST_JOY_PULLUP: assert property ( // [R15]
        joystick_button_pullup_out == {4{st_q.ctrl[1][2] && joystick_pins_selected_in}})
        else $error("joystick button pull-ups wrong");

    AST_MIDI_LEGACY: assert property ( // [R20]
        midi_legacy_only_out == (st_q.act[2][0] && !st_q.ctrl[2][3]))
        else $error("MIDI legacy mode wrong");

    AST_MIDI_FULL: assert property ( // [R21]
        midi_full_set_out == (st_q.act[2][0] && st_q.ctrl[2][3]))
        else $error("MIDI enhanced mode wrong");

    AST_MIDI_PULLUP: assert property ( // [R18]
        midi_receive_pullup_out == st_q.ctrl[2][2])
        else $error("MIDI receive pull-up wrong");

endmodule : ld_config_bank

// ===== ahb_host_model.sv
/*
 * Bus host model: issues single AHB-Lite word transfers to the bank.
 * Assumes one slave whose hreadyout is fed back as hready_in.
 */
`timescale 1ns/1ns
module ahb_host_model (
    // Clock and slave answer
    input  wire logic        clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    // Master outputs
    output logic             hsel_out,
    output logic [31:0]      haddr_out,
    output logic [1:0]       htrans_out,
    output logic             hwrite_out,
    output logic [2:0]       hsize_out,
    output logic [31:0]      hwdata_out
);
    // Idle values at time zero; data lines start on a marker word, and a read's data phase after a write carries the written word again
    initial begin
        hsel_out   = 1'b0;
        haddr_out  = 32'h0000_0000;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h5a5a_a5a5;
    end

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 64);
        if (hready_in !== 1'b1) begin
            ld_config_timeout_joystick_midi_tb.miscompares++;
            ld_config_timeout_joystick_midi_tb.test_done();
        end
    endtask : wait_ready

    // One single transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        hsel_out   <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out  <= addr;
        hwrite_out <= wr;
        hsize_out  <= 3'h2;
        wait_ready();
        htrans_out <= 2'h0;
        haddr_out  <= ~addr;
        hwdata_out <= wr ? wd : ~hwdata_out;
        wait_ready();
        rd = hrdata_in;
        hsel_out   <= 1'b0;
        hwdata_out <= ~hwdata_out;
    endtask : xfer
endmodule : ahb_host_model

// ===== ld_config_timeout_joystick_midi_tb.sv
/*
 * Self-checking bench for the configuration bank, against a byte-array model.
 * Assumes the bank answers with zero wait states; driven by ahb_host_model.
 */
`timescale 1ns/1ns
module ld_config_timeout_joystick_midi_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ev     = 1'b0;
    logic        sel    = 1'b0;
    logic        hsel, hwrite, hready, hresp, jleg, jfull, mleg, mfull, mpull;
    logic        clk_en, fhigh, ppull, tpull, ireq, wake;
    logic [1:0]  htrans;
    logic [2:0]  hsize, racc, tri3;
    logic [3:0]  iline, jpull;
    logic [15:0] tbase, jbase, mbase;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  m [4][256];
    int          miscompares = 0;
    int          comparisons = 0;
    localparam logic [7:0] IDX [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hf0, 8'h42};
    localparam logic [17:0] DIR [12] = '{{2'h1, 8'h61, 8'h20}, {2'h1, 8'hf0, 8'h0c}, {2'h1, 8'h30, 8'h01},
        {2'h1, 8'h61, 8'h23}, {2'h2, 8'hf0, 8'h0c}, {2'h2, 8'h30, 8'h01}, {2'h2, 8'hf0, 8'h05},
        {2'h0, 8'h70, 8'h13}, {2'h0, 8'hf0, 8'h0c}, {2'h0, 8'h30, 8'h01}, {2'h0, 8'hf0, 8'h0f}, {2'h0, 8'h30, 8'h00}};

    // 25 MHz clock
    always #20 clk_in = ~clk_in;

    ld_config_bank ld_config_bank_i (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .runtime_access_out(racc),
        .pins_tristate_out(tri3), .timeout_event_in(ev), .timeout_clk_en_out(clk_en),
        .timeout_output_force_high_out(fhigh), .timeout_output_push_pull_out(ppull),
        .timeout_output_pullup_out(tpull), .timeout_irq_line_out(iline), .timeout_irq_req_out(ireq),
        .timeout_wake_out(wake), .timeout_supervisor_base_out(tbase), .joystick_pins_selected_in(sel),
        .joystick_legacy_only_out(jleg), .joystick_full_set_out(jfull), .joystick_port_base_out(jbase),
        .joystick_button_pullup_out(jpull), .midi_legacy_only_out(mleg), .midi_full_set_out(mfull),
        .midi_port_base_out(mbase), .midi_receive_pullup_out(mpull));

    ahb_host_model ahb_host_model_i (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

    // Writable bits per register; read-only and unmapped places take nothing
    function automatic logic [7:0] wmask(input logic [1:0] ld, input logic [7:0] idx);
        if (ld == 2'h3) return 8'h00;
        case (idx)
            8'h30: return 8'h01;
            8'h60, 8'h70: return 8'hff;
            8'h61: return (ld == 2'h0) ? 8'hfc : (ld == 2'h2) ? 8'hfe : 8'hff;
            8'h71: return 8'h02;
            8'hf0: return (ld == 2'h0) ? 8'h0f : 8'h0d;
            default: return 8'h00;
        endcase
    endfunction : wmask

    // Reset contents of the model
    task automatic model_reset();
        foreach (m[i, j]) m[i][j] = 8'h00;
        for (int i = 0; i < 3; i++) begin
            m[i][8'h71] = 8'h03;
            m[i][8'h74] = 8'h04;
            m[i][8'h75] = 8'h04;
        end
        m[1][8'h60] = 8'h02;
        m[2][8'h60] = 8'h03;
        m[1][8'h61] = 8'h01;
        m[2][8'h61] = 8'h30;
        m[0][8'hf0] = 8'h02;
    endtask : model_reset

    task automatic check(input logic [95:0] e, input logic [95:0] g);
        comparisons++;
        if (e !== g) begin
            miscompares++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask : check

    task automatic rd(input logic [1:0] ld, input logic [7:0] idx);
        logic [31:0] r;
        ahb_host_model_i.xfer(1'b0, {20'h0, ld, idx, 2'b00}, $urandom, r);
        check(96'(m[ld][idx]), 96'(r));
    endtask : rd

    // Level outputs worked out from the model bytes
    task automatic outs();
        logic [7:0] c0, c1, c2, s0;
        logic       a0, a1, a2, req, jf;
        c0 = m[0][8'hf0];
        c1 = m[1][8'hf0];
        c2 = m[2][8'hf0];
        s0 = m[0][8'h70];
        a0 = m[0][8'h30][0];
        a1 = m[1][8'h30][0];
        a2 = m[2][8'h30][0];
        req = ev & (s0[3:0] != 4'h0);
        jf = a1 & c1[3] & (m[1][8'h61][3:0] == 4'h0);
        check(96'({2'b10, a2, a1, a0, c2[0] & ~a2, c1[0] & ~a1, c0[0] & ~a0, c0[1] & a0, ~c0[1], c0[3], c0[2],
            s0[3:0], req, req & s0[4], m[0][8'h60], m[0][8'h61], a1 & ~jf, jf, m[1][8'h60], m[1][8'h61],
            {4{c1[2] & sel}}, a2 & ~c2[3], a2 & c2[3], m[2][8'h60], m[2][8'h61], c2[2]}),
            96'({hready, hresp, racc, tri3, clk_en, fhigh, ppull, tpull, iline, ireq, wake, tbase, jleg, jfull,
            jbase, jpull, mleg, mfull, mbase, mpull}));
    endtask : outs

    // Write, update the model, move the side inputs, then compare outputs and read back
    task automatic step(input logic [1:0] ld, input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        ahb_host_model_i.xfer(1'b1, {20'h0, ld, idx, 2'b00}, d, r);
        m[ld][idx] = (m[ld][idx] & ~wmask(ld, idx)) | (d[7:0] & wmask(ld, idx));
        @(posedge clk_in);
        ev  <= 1'($urandom);
        sel <= 1'($urandom);
        #1 outs();
        rd(ld, idx);
    endtask : step

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Two passes, the second resetting in mid-run; joystick base kept aligned first
    initial begin
        void'($urandom(25));
        for (int p = 0; p < 2; p++) begin
            rst_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            rst_in <= 1'b0;
            model_reset();
            #1 outs();
            for (int ld = 0; ld < 4; ld++)
                for (int k = 0; k < 9; k++) rd(2'(ld), IDX[k]);
            foreach (DIR[k]) step(DIR[k][17:16], DIR[k][15:8], 32'(DIR[k][7:0]));
            repeat (60) step(2'($urandom_range(3)), IDX[$urandom_range(8)], $urandom);
        end
        test_done();
    end
endmodule : ld_config_timeout_joystick_midi_tb
